// [src/clkdist_top.sv]
/*
 Clock selection, bus and digital dividers, timer wheels and one-second
 tick, with a plain register port and a masked interrupt.
 Assumes every clock source input is a level synchronous to I_REF_CLK
 and much slower than it, so that each edge is seen as one sample.
*/
// Decided for this implementation: the register offsets and strobed register access.
// Overview of operation
// [RULE_01] Five-bit fast wheel on 100 kHz edges
// [RULE_02] Fast wheel wraps to zero at terminal
// [RULE_03] Fast wheel event sets interrupt when enabled
// [RULE_04] Thirty-three k clock is 100 kHz over three
// [RULE_05] Divided outputs keep fifty percent duty
// [RULE_06] 100 kHz selectable as system clock
// [RULE_07] Central wheel periodic wake, optional interrupt
// [RULE_08] Watch crystal feeds sleep timer and RTC
// [RULE_09] RTC raises one-second interrupt tick
// [RULE_10] System clock selects one source
// [RULE_11] Sixteen-bit divider makes bus clock
// [RULE_12] CPU clock equals bus clock
// [RULE_13] Eight programmable sixteen-bit digital dividers
// [RULE_14] Each divider picks any of seven sources
// [RULE_15] Each divider may take its routed clock
// [RULE_16] Divider reloads at limit, output toggles
// [RULE_17] Fast wheel pending flag held until cleared
`timescale 1ns/1ps
`default_nettype none
module clkdist_top
   import clkdist_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic I_CLK_EN,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [NUM_SRC-1:0] I_CLK_SRC,
   input wire logic [NUM_DIG-1:0] I_ROUTED_CLK,
   output logic [DATA_W-1:0] O_RDATA,
   output logic O_IRQ,
   output logic O_SYS_CLK,
   output logic O_BUS_CLK,
   output logic O_CPU_CLK,
   output logic [NUM_DIG-1:0] O_DIG_CLK,
   output logic O_CLK_33K,
   output logic O_SLEEP_CLK,
   output logic O_WAKEUP,
   output logic O_RTC_TICK
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   ctrl_t ctrl_reg;
   dig_cfg_t dig_cfg_reg [NUM_DIG];
   logic [15:0] bus_div_reg;
   logic [4:0] ftw_tc_reg;
   logic [15:0] ctw_period_reg;
   logic [EVT_W-1:0] status_reg;
   logic [EVT_W-1:0] status_next;
   logic [EVT_W-1:0] mask_reg;
   logic [EVT_W-1:0] evt_set;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rd_value;
   logic [NUM_SRC-1:0] src_prev_reg;
   logic [NUM_SRC-1:0] src_rise;
   logic [4:0] ftw_cnt_reg;
   logic ftw_hit;
   logic [15:0] ctw_cnt_reg;
   logic ctw_hit;
   logic [14:0] rtc_cnt_reg;
   logic rtc_hit;
   logic [1:0] div3_cnt_reg;
   logic clk33_reg;
   logic sys_clk_reg;
   logic sys_prev_reg;
   logic [15:0] bus_cnt_reg;
   logic bus_clk_reg;
   logic [NUM_DIG-1:0] dig_in;
   logic [NUM_DIG-1:0] dig_prev_reg;
   logic [15:0] dig_cnt_reg [NUM_DIG];
   logic [NUM_DIG-1:0] dig_clk_reg;
   logic wake_reg;
   logic rtc_tick_reg;
   logic sleep_clk_reg;
   logic irq_reg;
   logic wr_status;
   logic [2:0] dig_idx;
   logic dig_hit;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);

   // ---------------------------------------------------------------
   // Source edge detection
   // ---------------------------------------------------------------
   assign src_rise = I_CLK_SRC & ~src_prev_reg;
   // Previous source levels
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         src_prev_reg <= '0;
      end else if (I_CLK_EN) begin
         src_prev_reg <= I_CLK_SRC;
      end
   end

   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   assign dig_idx = I_ADDR[4:2];
   assign dig_hit = (I_ADDR >= REG_DIG_BASE) && (I_ADDR <= REG_DIG_LAST)
                    && (I_ADDR[1:0] == 2'h0);
   assign wr_status = I_WR && (I_ADDR == REG_STATUS);
   // Configuration writes
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl_reg <= CTRL_RST;
         bus_div_reg <= BUS_DIV_RST;
         ftw_tc_reg <= FTW_TC_RST;
         ctw_period_reg <= CTW_PERIOD_RST;
         mask_reg <= '0;
         for (int i = 0; i < NUM_DIG; i++) begin
            dig_cfg_reg[i] <= DIG_CFG_RST;
         end
      end else if (I_CLK_EN && I_WR) begin
         unique case (I_ADDR)
            REG_CTRL: ctrl_reg <= I_WDATA[6:0];
            REG_BUS_DIV: bus_div_reg <= I_WDATA[15:0];
            REG_FTW_TC: ftw_tc_reg <= I_WDATA[4:0];
            REG_CTW_PERIOD: ctw_period_reg <= I_WDATA[15:0];
            REG_MASK: mask_reg <= I_WDATA[EVT_W-1:0];
            default: begin
               if (dig_hit) begin
                  dig_cfg_reg[dig_idx] <= I_WDATA[18:0];
               end
            end
         endcase
      end
   end

   // Read multiplexer, unmapped reads as zero
   always_comb begin
      rd_value = '0;
      unique case (I_ADDR)
         REG_CTRL: rd_value[6:0] = ctrl_reg;
         REG_BUS_DIV: rd_value[15:0] = bus_div_reg;
         REG_FTW_TC: rd_value[4:0] = ftw_tc_reg;
         REG_CTW_PERIOD: rd_value[15:0] = ctw_period_reg;
         REG_STATUS: rd_value[EVT_W-1:0] = status_reg;
         REG_MASK: rd_value[EVT_W-1:0] = mask_reg;
         REG_COUNTS: rd_value = {ctw_cnt_reg, 11'h000, ftw_cnt_reg};
         default: begin
            if (dig_hit) begin
               rd_value[18:0] = dig_cfg_reg[dig_idx];
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdata_reg <= '0;
      end else if (I_CLK_EN) begin
         rdata_reg <= I_RD ? rd_value : '0;
      end
   end

   // ---------------------------------------------------------------
   // Fast timer wheel
   // ---------------------------------------------------------------
   assign ftw_hit = ctrl_reg.ftw_en && src_rise[SRC_LOW_100K]
                    && (ftw_cnt_reg == ftw_tc_reg);

   // Counts 100 kHz edges, wraps itself at terminal
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         ftw_cnt_reg <= '0;
      end else if (I_CLK_EN) begin
         if (!ctrl_reg.ftw_en) begin
            ftw_cnt_reg <= '0;
         end else if (ftw_hit) begin
            ftw_cnt_reg <= '0; // [RULE_02]
         end else if (src_rise[SRC_LOW_100K]) begin
            ftw_cnt_reg <= ftw_cnt_reg + 5'h01; // [RULE_01]
         end
      end
   end
   a_ftw_wrap_zero: assert property (I_CLK_EN && ftw_hit |=> // [RULE_02]
      ftw_cnt_reg == 5'h00) else $error("fast wheel did not wrap");
   a_ftw_step_one: assert property ( // [RULE_01]
      I_CLK_EN && ctrl_reg.ftw_en && src_rise[SRC_LOW_100K] && !ftw_hit
      && !(I_WR && I_ADDR == REG_CTRL)
      |=> ftw_cnt_reg == $past(ftw_cnt_reg) + 5'h01)
      else $error("fast wheel did not advance");

   // ---------------------------------------------------------------
   // Central timer wheel and wakeup
   // ---------------------------------------------------------------
   assign ctw_hit = ctrl_reg.ctw_en && src_rise[SRC_WATCH_XTAL]
                    && (ctw_cnt_reg == ctw_period_reg);

   // Periodic wake counter on the watch crystal
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctw_cnt_reg <= '0;
         wake_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         wake_reg <= ctw_hit; // [RULE_07]
         if (!ctrl_reg.ctw_en) begin
            ctw_cnt_reg <= '0;
         end else if (src_rise[SRC_WATCH_XTAL]) begin
            ctw_cnt_reg <= nxt16(ctw_cnt_reg, ctw_period_reg);
         end
      end
   end
   a_ctw_wake_pulse: assert property (I_CLK_EN && ctw_hit |=> // [RULE_07]
      wake_reg && ctw_cnt_reg == 16'h0000)
      else $error("central wheel wake missing");

   // ---------------------------------------------------------------
   // One-second tick and sleep timer clock
   // ---------------------------------------------------------------
   assign rtc_hit = src_rise[SRC_WATCH_XTAL] && (rtc_cnt_reg == RTC_LAST);
   // Watch crystal edges counted to one second
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         rtc_cnt_reg <= '0;
         rtc_tick_reg <= 1'b0;
         sleep_clk_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         sleep_clk_reg <= I_CLK_SRC[SRC_WATCH_XTAL]; // [RULE_08]
         rtc_tick_reg <= rtc_hit; // [RULE_09]
         if (src_rise[SRC_WATCH_XTAL]) begin
            rtc_cnt_reg <= rtc_cnt_reg + 15'h0001; // [RULE_08]
         end
      end
   end
   a_rtc_one_sec: assert property (I_CLK_EN && rtc_hit |=> // [RULE_09]
      rtc_tick_reg && status_reg[ST_RTC])
      else $error("one-second tick missing");

   // ---------------------------------------------------------------
   // Thirty-three kHz clock
   // ---------------------------------------------------------------
   // Toggle every third 100 kHz edge, either polarity, for 50% duty
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         div3_cnt_reg <= '0;
         clk33_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         if (I_CLK_SRC[SRC_LOW_100K] != src_prev_reg[SRC_LOW_100K]) begin
            if (div3_cnt_reg == DIV3_LAST) begin
               div3_cnt_reg <= '0;
               clk33_reg <= ~clk33_reg; // [RULE_04] [RULE_05]
            end else begin
               div3_cnt_reg <= div3_cnt_reg + 2'h1;
            end
         end
      end
   end
   a_div3_toggle: assert property ( // [RULE_04]
      I_CLK_EN && div3_cnt_reg == DIV3_LAST
      && I_CLK_SRC[SRC_LOW_100K] != src_prev_reg[SRC_LOW_100K]
      |=> clk33_reg != $past(clk33_reg) && div3_cnt_reg == 2'h0)
      else $error("divide by three missed its toggle");

   // ---------------------------------------------------------------
   // System, bus and CPU clocks
   // ---------------------------------------------------------------
   // Selected source, 100 kHz among the choices; code 7 falls to 100 kHz
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         sys_clk_reg <= 1'b0;
         sys_prev_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         sys_prev_reg <= sys_clk_reg;
         if (ctrl_reg.sys_sel < 3'(NUM_SRC)) begin
            sys_clk_reg <= I_CLK_SRC[ctrl_reg.sys_sel]; // [RULE_10]
         end else begin
            sys_clk_reg <= I_CLK_SRC[SRC_LOW_100K]; // [RULE_06]
         end
      end
   end
   a_sys_follow: assert property ( // [RULE_10]
      I_CLK_EN && ctrl_reg.sys_sel == SRC_LOW_100K
      |=> sys_clk_reg == $past(I_CLK_SRC[SRC_LOW_100K]))
      else $error("system clock not following 100 kHz");

   // Bus divider on system clock edges; CPU shares its flop
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         bus_cnt_reg <= '0;
         bus_clk_reg <= 1'b0;
      end else if (I_CLK_EN && sys_clk_reg && !sys_prev_reg) begin
         bus_cnt_reg <= nxt16(bus_cnt_reg, bus_div_reg); // [RULE_11]
         if (bus_cnt_reg == bus_div_reg) begin
            bus_clk_reg <= ~bus_clk_reg; // [RULE_05] [RULE_16]
         end
      end
   end
   a_bus_toggle: assert property ( // [RULE_11]
      I_CLK_EN && sys_clk_reg && !sys_prev_reg
      && bus_cnt_reg == bus_div_reg
      |=> bus_clk_reg != $past(bus_clk_reg) && bus_cnt_reg == 16'h0000)
      else $error("bus divider missed its toggle");

   // ---------------------------------------------------------------
   // Digital clock dividers
   // ---------------------------------------------------------------
   // Source pick per divider: seven sources or its routed clock
   always_comb begin
      dig_in = '0;
      for (int i = 0; i < NUM_DIG; i++) begin
         if (dig_cfg_reg[i].src == DIG_SRC_ROUTED) begin
            dig_in[i] = I_ROUTED_CLK[i]; // [RULE_15]
         end else if (dig_cfg_reg[i].src < 3'(NUM_SRC)) begin
            dig_in[i] = I_CLK_SRC[dig_cfg_reg[i].src]; // [RULE_14]
         end
      end
   end

   // Count input edges to limit, reload and toggle
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         dig_prev_reg <= '0;
         dig_clk_reg <= '0;
         for (int i = 0; i < NUM_DIG; i++) begin
            dig_cnt_reg[i] <= '0;
         end
      end else if (I_CLK_EN) begin
         dig_prev_reg <= dig_in;
         for (int i = 0; i < NUM_DIG; i++) begin
            if (dig_in[i] && !dig_prev_reg[i]) begin
               dig_cnt_reg[i] <= nxt16(dig_cnt_reg[i],
                                       dig_cfg_reg[i].div); // [RULE_13]
               if (dig_cnt_reg[i] == dig_cfg_reg[i].div) begin
                  dig_clk_reg[i] <= ~dig_clk_reg[i]; // [RULE_16] [RULE_05]
               end
            end
         end
      end
   end
   a_dig0_toggle: assert property ( // [RULE_16]
      I_CLK_EN && dig_in[0] && !dig_prev_reg[0]
      && dig_cnt_reg[0] == dig_cfg_reg[0].div
      |=> dig_clk_reg[0] != $past(dig_clk_reg[0])
      && dig_cnt_reg[0] == 16'h0000)
      else $error("digital divider missed its toggle");

   // ---------------------------------------------------------------
   // Interrupt status, mask and output
   // ---------------------------------------------------------------
   assign evt_set[ST_FTW] = ftw_hit && ctrl_reg.ftw_ie; // [RULE_03]
   assign evt_set[ST_CTW] = ctw_hit && ctrl_reg.ctw_ie; // [RULE_07]
   assign evt_set[ST_RTC] = rtc_hit; // [RULE_09]

   // Write one to clear; a new event wins over the clear
   always_comb begin
      status_next = status_reg;
      if (wr_status) begin
         status_next = status_reg & ~I_WDATA[EVT_W-1:0];
      end
      status_next = status_next | evt_set; // [RULE_17]
   end

   // Sticky status and registered interrupt level
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         status_reg <= '0;
         irq_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         status_reg <= status_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end
   a_ftw_irq_set: assert property (I_CLK_EN && evt_set[ST_FTW] // [RULE_03]
      |=> status_reg[ST_FTW])
      else $error("fast wheel event not flagged");
   a_ftw_pending: assert property ( // [RULE_17]
      I_CLK_EN && status_reg[ST_FTW]
      && !(wr_status && I_WDATA[ST_FTW])
      |=> status_reg[ST_FTW])
      else $error("pending flag lost without clear");

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign O_RDATA = rdata_reg;
   assign O_IRQ = irq_reg;
   assign O_SYS_CLK = sys_clk_reg;
   assign O_BUS_CLK = bus_clk_reg;
   assign O_CPU_CLK = bus_clk_reg; // [RULE_12]
   assign O_DIG_CLK = dig_clk_reg;
   assign O_CLK_33K = clk33_reg;
   assign O_SLEEP_CLK = sleep_clk_reg;
   assign O_WAKEUP = wake_reg;
   assign O_RTC_TICK = rtc_tick_reg;
endmodule : clkdist_top
`default_nettype wire

// [src/clkdist_pkg.sv]
/*
 Constants, field layouts and shared helpers for the clock distribution
 block. Assumes a single reference clock; all clock sources arrive as
 levels synchronous to that clock.
*/
package clkdist_pkg;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_SRC = 7;
   localparam int NUM_DIG = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int EVT_W = 3;

   // ---------------------------------------------------------------
   // Clock source indexes
   // ---------------------------------------------------------------
   localparam logic [2:0] SRC_LOW_100K = 3'h0;
   localparam logic [2:0] SRC_WATCH_XTAL = 3'h1;
   localparam logic [2:0] SRC_HF_XTAL = 3'h2;
   localparam logic [2:0] SRC_FABRIC = 3'h3;
   localparam logic [2:0] DIG_SRC_ROUTED = 3'h7;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BUS_DIV = 8'h04;
   localparam logic [7:0] REG_FTW_TC = 8'h08;
   localparam logic [7:0] REG_CTW_PERIOD = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_MASK = 8'h14;
   localparam logic [7:0] REG_COUNTS = 8'h18;
   localparam logic [7:0] REG_DIG_BASE = 8'h20;
   localparam logic [7:0] REG_DIG_LAST = 8'h3C;

   // ---------------------------------------------------------------
   // Status bit positions
   // ---------------------------------------------------------------
   localparam int ST_FTW = 0;
   localparam int ST_CTW = 1;
   localparam int ST_RTC = 2;

   // ---------------------------------------------------------------
   // Field layouts
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ctw_ie;
      logic ctw_en;
      logic ftw_ie;
      logic ftw_en;
      logic [2:0] sys_sel;
   } ctrl_t;

   typedef struct packed {
      logic [2:0] src;
      logic [15:0] div;
   } dig_cfg_t;

   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam ctrl_t CTRL_RST = 7'h00;
   localparam logic [15:0] BUS_DIV_RST = 16'h0000;
   localparam logic [4:0] FTW_TC_RST = 5'h1F;
   localparam logic [15:0] CTW_PERIOD_RST = 16'hFFFF;
   localparam dig_cfg_t DIG_CFG_RST = 19'h00000;
   localparam logic [14:0] RTC_LAST = 15'h7FFF;
   localparam logic [1:0] DIV3_LAST = 2'h2;

   // Wrapping 16-bit counter step
   function automatic logic [15:0] nxt16(input logic [15:0] cnt,
                                         input logic [15:0] lim);
      nxt16 = (cnt == lim) ? 16'h0000 : cnt + 16'h0001;
   endfunction : nxt16
endpackage : clkdist_pkg

// [verif/clk_src_model.sv]
/*
 Far-side model: square-wave clock sources and routed fabric clocks.
 Assumes one reference clock; levels change just after its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_src_model (
   input wire logic i_clk,
   input wire logic i_rst,
   output logic [6:0] o_src,
   output logic [7:0] o_routed
);
   // Half periods in reference cycles, watch crystal fastest
   localparam int HP[15] = '{4, 1, 3, 5, 2, 6, 7, 2, 3, 4, 5, 2, 3, 4, 5};
   int cnt[15];
   logic [14:0] lvl = 15'h0000;
   assign o_src = lvl[6:0];
   assign o_routed = lvl[14:7];
   // Free-running sources, low while reset
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lvl <= 15'h0000;
         for (int i = 0; i < 15; i++) cnt[i] <= 0;
      end else begin
         for (int i = 0; i < 15; i++) begin
            if (cnt[i] == HP[i] - 1) begin
               cnt[i] <= 0;
               lvl[i] <= ~lvl[i];
            end else begin
               cnt[i] <= cnt[i] + 1;
            end
         end
      end
   end
endmodule : clk_src_model
`default_nettype wire

// [verif/testbench.sv]
/*
 Self-checking bench for the clock distribution block.
 Assumes the source model and a 250 MHz reference clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
   import clkdist_pkg::*;
;
   // ---------------------------------------------------------------
   // Stimulus, tasks and checks
   // ---------------------------------------------------------------
   localparam logic [7:0] RA[6] = '{REG_CTRL, REG_BUS_DIV, REG_FTW_TC,
      REG_CTW_PERIOD, REG_MASK, 8'h44};
   localparam logic [31:0] RM[6] = '{32'h7F, 32'hFFFF, 32'h1F, 32'hFFFF,
      32'h7, 32'h0};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0000_0000;
   logic [NUM_SRC-1:0] src;
   logic [NUM_DIG-1:0] routed, dig;
   logic [DATA_W-1:0] rdata;
   logic irq, sys_clk, bus_clk, cpu_clk, clk33, sleep_clk, wake, tick;
   logic [13:0] mon;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   // Watched outputs by index
   assign mon = {tick, irq, wake, clk33, bus_clk, sys_clk, dig};
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

   clk_src_model src_model (.i_clk(clk), .i_rst(rst), .o_src(src),
      .o_routed(routed));
   clkdist_top uut (.I_REF_CLK(clk), .I_RST(rst), .I_CLK_EN(en),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
      .I_CLK_SRC(src), .I_ROUTED_CLK(routed), .O_RDATA(rdata),
      .O_IRQ(irq), .O_SYS_CLK(sys_clk), .O_BUS_CLK(bus_clk),
      .O_CPU_CLK(cpu_clk), .O_DIG_CLK(dig), .O_CLK_33K(clk33),
      .O_SLEEP_CLK(sleep_clk), .O_WAKEUP(wake), .O_RTC_TICK(tick));

   function automatic int src_per(input int s);
      return 2 * src_model.HP[s];
   endfunction : src_per

   task automatic print_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_t(input int got, input int exp);
      chk(32'(got), 32'(exp));
   endtask : chk_t

   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask : do_reset

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask : rd_reg

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask : chk_reg

   // Bounded wait for a level, returns the cycle stamp
   task automatic wait_lvl(input int k, input logic v, output int t);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (mon[k] !== v && n < 70000);
      if (mon[k] !== v) begin
         n_mismatch++; // Limit ran out
      end
      t = cyc;
   endtask : wait_lvl

   // Period and high time of one watched output
   task automatic meas(input int k, output int per, output int hi);
      int t, t0;
      wait_lvl(k, 1'b0, t);
      wait_lvl(k, 1'b1, t0);
      wait_lvl(k, 1'b0, t);
      hi = t - t0;
      wait_lvl(k, 1'b1, t);
      per = t - t0;
      @(posedge clk);
   endtask : meas

   // Main sequence
   initial begin
      int t, t0, per, hi, s, d, ps;
      logic [31:0] v;
      void'($urandom(32'h45a6));
      do_reset();
      chk_reg(REG_CTRL, 32'h0000_0000);
      chk_reg(REG_BUS_DIV, 32'h0000_0000);
      chk_reg(REG_FTW_TC, 32'h0000_001F);
      chk_reg(REG_CTW_PERIOD, 32'h0000_FFFF);
      chk_reg(REG_STATUS, 32'h0000_0000);
      chk_reg(REG_MASK, 32'h0000_0000);
      chk_reg(REG_DIG_BASE, 32'h0000_0000);
      for (int i = 0; i < 14; i++) begin
         v = $urandom();
         wr_reg((i < 8) ? REG_DIG_BASE + 8'(4 * i) : RA[i-8], v);
         chk_reg((i < 8) ? REG_DIG_BASE + 8'(4 * i) : RA[i-8],
            v & ((i < 8) ? 32'h7FFFF : RM[i-8]));
      end
      do_reset();
      chk_reg(REG_DIG_BASE + 8'h1C, 32'h0000_0000);
      for (int i = 0; i < NUM_DIG; i++) begin
         s = (i % 3 == 0) ? 7 : $urandom_range(6, 0);
         d = $urandom_range(3, 0);
         wr_reg(REG_DIG_BASE + 8'(4 * i), {13'h0000, 3'(s), 16'(d)});
         ps = (s == 7) ? src_per(7 + i) : src_per(s);
         meas(i, per, hi);
         meas(i, per, hi);
         chk_t(per, 2 * (d + 1) * ps);
         chk_t(hi, (d + 1) * ps);
      end
      for (int j = 0; j < 4; j++) begin
         s = (j < 2) ? 7 * j : $urandom_range(6, 0);
         wr_reg(REG_CTRL, 32'(s));
         wr_reg(REG_BUS_DIV, 32'(j));
         ps = src_per((s == 7) ? 0 : s);
         meas(8, per, hi);
         meas(8, per, hi);
         chk_t(per, ps);
         meas(9, per, hi);
         meas(9, per, hi);
         chk_t(per, 2 * (j + 1) * ps);
         chk_t(hi, (j + 1) * ps);
         chk({31'h0, cpu_clk}, {31'h0, bus_clk});
      end
      en <= 1'b0;
      wr_reg(REG_BUS_DIV, 32'h0000_1234);
      en <= 1'b1;
      chk_reg(REG_BUS_DIV, 32'h0000_0003);
      meas(10, per, hi);
      chk_t(per, 3 * src_per(0));
      chk_t(hi, 3 * src_per(0) / 2);
      @(negedge clk);
      chk({31'h0, sleep_clk}, {31'h0, ~src[1]});
      @(posedge clk);
      // Fast wheel: period, sticky flag, mask, option
      d = $urandom_range(6, 2);
      wr_reg(REG_FTW_TC, 32'(d));
      wr_reg(REG_MASK, 32'h0000_0001);
      wr_reg(REG_CTRL, 32'h0000_0018);
      wait_lvl(12, 1'b1, t0);
      repeat (5) @(posedge clk);
      chk_reg(REG_STATUS, 32'h0000_0001);
      rd_reg(REG_COUNTS, v);
      chk_t(v[4:0] <= d, 1);
      wr_reg(REG_STATUS, 32'h0000_0001);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      wait_lvl(12, 1'b1, t);
      chk_t(t - t0, (d + 1) * src_per(0));
      @(posedge clk);
      wr_reg(REG_MASK, 32'h0000_0000);
      wr_reg(REG_STATUS, 32'h0000_0001);
      repeat (60) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      chk_reg(REG_STATUS, 32'h0000_0001);
      wr_reg(REG_CTRL, 32'h0000_0008);
      wr_reg(REG_STATUS, 32'h0000_0007);
      repeat (60) @(posedge clk);
      chk_reg(REG_STATUS, 32'h0000_0000);
      // Central wheel wakeup
      d = $urandom_range(9, 3);
      wr_reg(REG_CTW_PERIOD, 32'(d));
      wr_reg(REG_CTRL, 32'h0000_0060);
      meas(11, per, hi);
      meas(11, per, hi);
      chk_t(per, (d + 1) * src_per(1));
      chk_t(hi, 1);
      chk_reg(REG_STATUS, 32'h0000_0002);
      // One-second tick from the watch crystal
      wr_reg(REG_CTRL, 32'h0000_0020);
      wr_reg(REG_STATUS, 32'h0000_0007);
      wr_reg(REG_MASK, 32'h0000_0004);
      wait_lvl(13, 1'b1, t);
      chk_t((t - 32768 * src_per(1)) / 8, 0);
      @(posedge clk);
      chk_reg(REG_STATUS, 32'h0000_0004);
      chk({31'h0, irq}, 32'h1);
      wr_reg(REG_STATUS, 32'h0000_0004);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      print_verdict();
   end

   // Watchdog against a hang
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
